// ### mpsf_checker.sv
// checker: port assertions of the status flag block
`timescale 1ns/1ns
module mpsf_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mpsf_pkg::MPSF_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pwm side
	input wire logic count_down,
	input wire logic [2:0] interval_period_count,
	input wire logic period_evt,
	input wire logic bottom_evt,
	input wire logic [5:0] duty_match,
	input wire logic [5:0] trig_match,
	input wire logic [5:0] adc_trig_out,
	input wire logic irq
);
	import mpsf_pkg::*;
	logic [7:0] en_q;
	logic [11:0] mode_q;
	logic [5:0] fire_w;
	logic [5:0] on_w;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= 8'h00;
			mode_q <= 12'h000;
		end else if (pready && pwrite && !pslverr) begin
			if (paddr == MPSF_OFF_IRQ_EN && pstrb[0])
				en_q <= pwdata[7:0];
			for (int i = 0; i < 6; i++)
				if (paddr == 12'h008 + 12'(4 * i) && pstrb[2])
					mode_q[2*i +: 2] <= pwdata[17:16];
		end
	end
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			on_w[i] = |mode_q[2*i +: 2];
			fire_w[i] = trig_match[i] & (mode_q[2*i] & ~count_down
				| mode_q[2*i+1] & count_down);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable; endsequence
	sequence st_rd_s; pready && !pwrite && paddr == MPSF_OFF_STATUS; endsequence
	dir_read_a: assert property (st_rd_s |-> prdata[15] == $past(count_down))
		else $error("direction bit wrong");
	cnt_read_a: assert property (st_rd_s |->
		prdata[14:12] == $past(interval_period_count))
		else $error("period count field wrong");
	wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("access wait state wrong");
	err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 0)
		else $error("refused read data wrong");
	prd_irq_a: assert property (period_evt && en_q[7] |-> ##2 irq)
		else $error("period irq missing");
	bot_irq_a: assert property (bottom_evt && en_q[6] |-> ##2 irq)
		else $error("bottom irq missing");
	duty_irq_a: assert property (|(duty_match & en_q[5:0] & ~on_w) |-> ##2 irq)
		else $error("duty irq missing");
	trig_irq_a: assert property (|(fire_w & en_q[5:0]) |-> ##2 irq)
		else $error("trigger irq missing");
	trig_out_a: assert property (adc_trig_out == $past(fire_w))
		else $error("trigger output wrong");
	irq_mask_a: assert property ($past(en_q) == 8'h00 |-> !irq)
		else $error("masked irq raised");
endmodule
bind mpsf_top mpsf_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.count_down(count_down), .interval_period_count(interval_period_count),
	.period_evt(period_evt), .bottom_evt(bottom_evt),
	.duty_match(duty_match), .trig_match(trig_match),
	.adc_trig_out(adc_trig_out), .irq(irq));

// ### mpsf_pkg.sv
// package: offsets, field positions, reset values and modes of the status flag block
package mpsf_pkg;

	// number of pwm outputs and trigger channels
	localparam int unsigned MPSF_NCH = 6;
	localparam int unsigned MPSF_AW = 12;
	localparam int unsigned MPSF_FLAG_W = 8;

	// register byte offsets
	localparam logic [11:0] MPSF_OFF_STATUS = 12'h000;
	localparam logic [11:0] MPSF_OFF_IRQ_EN = 12'h004;
	localparam logic [11:0] MPSF_OFF_TRIG_BASE = 12'h008;
	localparam logic [11:0] MPSF_OFF_TRIG_LAST = 12'h01c;
	localparam logic [11:0] MPSF_OFF_SRC_VIEW = 12'h020;

	// status field positions
	localparam int unsigned MPSF_DIR_BIT = 15;
	localparam int unsigned MPSF_CNT_HI = 14;
	localparam int unsigned MPSF_CNT_LO = 12;
	localparam int unsigned MPSF_PRD_BIT = 7;
	localparam int unsigned MPSF_BOT_BIT = 6;
	localparam int unsigned MPSF_OUT_HI = 5;
	localparam int unsigned MPSF_OUT_LO = 0;

	// trigger channel register field positions
	localparam int unsigned MPSF_TMOD_HI = 17;
	localparam int unsigned MPSF_TMOD_LO = 16;

	// reset values
	localparam logic [7:0] MPSF_RST_FLAGS = 8'h00;
	localparam logic [7:0] MPSF_RST_IRQ_EN = 8'h00;
	localparam logic [5:0] MPSF_RST_TRIG = 6'h00;
	localparam logic [31:0] MPSF_RST_RDATA = 32'h0000_0000;

	// trigger mode encodings
	typedef enum logic [1:0] {
		MPSF_TM_DISABLED = 2'b00,
		MPSF_TM_UP = 2'b01,
		MPSF_TM_DOWN = 2'b10,
		MPSF_TM_UPDOWN = 2'b11
	} mpsf_tmode_t;

endpackage

// ### mpsf_src_sel.sv
// per-output choice between duty match and trigger counter match
`timescale 1ns/1ns
module mpsf_src_sel (
	// trigger mode of the paired channel
	input mpsf_pkg::mpsf_tmode_t mode,
	// counter direction, high while counting down
	input wire logic count_down,
	// raw match pulses
	input wire logic duty_match,
	input wire logic trig_match,
	// selected flag event and trigger fire
	output logic flag_evt,
	output logic trig_fire,
	output logic use_trig
);
	import mpsf_pkg::*;

	logic dir_ok;

	// disabled mode hands the flag to the duty match
	assign use_trig = (mode != MPSF_TM_DISABLED);

	// up and down matches qualified by direction, up-down matches in either direction
	assign dir_ok = (mode == MPSF_TM_UPDOWN) ||
		(mode == MPSF_TM_UP && !count_down) ||
		(mode == MPSF_TM_DOWN && count_down);

	assign trig_fire = trig_match && dir_ok;
	assign flag_evt = use_trig ? trig_fire : duty_match;
endmodule

// ### mpsf_top.sv
// motor pwm status register, event flags and interrupt over apb
//
// Overview of operation
// - status bit 15 reads 0 counting up, 1 counting down; read-only.
// - status bits 14..12 show the interval period-match count; read-only.
// - bit 7 set on a period event, cleared by writing one.
// - bit 6 set on a bottom event, cleared by writing one.
// - bits 5..0 are wh, vh, uh, wl, vl, ul flags, write one clears.
// - flag uses duty match only while its paired channel 6..1 disabled.
// - bits 5..0 shared; disabled trigger mode means duty match sets flag.
// - any enabled trigger mode means the trigger compare match sets flag.
// - source choice follows the mode field in each channel's register.
// - enable bits 5..0 gate duty or trigger event by the same mode.
// - mode 00 disabled, 01 up-count match, 10 down-count match.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module mpsf_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mpsf_pkg::MPSF_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pwm counter state
	input wire logic count_down,
	input wire logic [2:0] interval_period_count,
	// pwm events, one-cycle pulses
	input wire logic period_evt,
	input wire logic bottom_evt,
	input wire logic [5:0] duty_match,
	input wire logic [5:0] trig_match,
	// outputs
	output logic [5:0] adc_trig_out,
	output logic irq
);
	import mpsf_pkg::*;

	// elaboration check: the status layout serves exactly six outputs
	if (MPSF_NCH != 6) begin : g_nch_chk
		$error("mpsf_top: six output channels expected");
	end

	// merge write data into old value under byte strobes
	function automatic logic [31:0] strb_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	// channel index of a trigger register offset
	function automatic logic [2:0] trig_index(
		input logic [MPSF_AW-1:0] a
	);
		logic [MPSF_AW-1:0] d;
		d = a - MPSF_OFF_TRIG_BASE;
		return d[4:2];
	endfunction

	// apb handshake state
	logic ack_q;
	logic ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic access;
	logic capture;
	logic wr_fire;

	// address decode
	logic aligned;
	logic sel_status;
	logic sel_irq_en;
	logic sel_trig;
	logic sel_src;
	logic mapped;
	logic [2:0] trig_idx;

	// register state
	logic [7:0] irq_en_q;
	logic [7:0] irq_en_d;
	mpsf_tmode_t tmode_q [MPSF_NCH];
	mpsf_tmode_t tmode_d [MPSF_NCH];
	logic [5:0] trig_out_q;
	logic irq_q;
	logic irq_d;

	// flag logic
	logic [7:0] flags;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [5:0] out_evt;
	logic [5:0] trig_fire;
	logic [5:0] use_trig;

	// read views
	logic [31:0] status_view;
	logic [31:0] irq_en_view;
	logic [31:0] trig_view;
	logic [31:0] src_view;
	logic [31:0] rd_mux;

	// one wait state: read data is captured, then pready
	assign access = psel && penable;
	assign capture = access && !ack_q;
	assign ack_d = capture;
	assign pready = access && ack_q;
	assign wr_fire = pready && pwrite;

	assign aligned = (paddr[1:0] == 2'b00);
	assign sel_status = aligned && (paddr == MPSF_OFF_STATUS);
	assign sel_irq_en = aligned && (paddr == MPSF_OFF_IRQ_EN);
	assign sel_trig = aligned && (paddr >= MPSF_OFF_TRIG_BASE) &&
		(paddr <= MPSF_OFF_TRIG_LAST);
	assign sel_src = aligned && (paddr == MPSF_OFF_SRC_VIEW);
	assign mapped = sel_status || sel_irq_en || sel_trig || sel_src;
	assign trig_idx = trig_index(paddr);

	// unmapped or misaligned access answers with an error
	assign pslverr = pready && !mapped;

	// per-output source selection from each channel's own mode
	genvar g;
	generate
		for (g = 0; g < MPSF_NCH; g++) begin : g_ch
			mpsf_src_sel u_sel (
				.mode(tmode_q[g]),
				.count_down(count_down),
				.duty_match(duty_match[g]),
				.trig_match(trig_match[g]),
				.flag_evt(out_evt[g]),
				.trig_fire(trig_fire[g]),
				.use_trig(use_trig[g])
			);
		end
	endgenerate

	// event set vector: period, bottom, then wh..ul on 5..0
	assign flag_set[MPSF_PRD_BIT] = period_evt;
	assign flag_set[MPSF_BOT_BIT] = bottom_evt;
	assign flag_set[MPSF_OUT_HI:MPSF_OUT_LO] = out_evt;

	// write one to clear the low status byte
	assign flag_clr = (wr_fire && sel_status && pstrb[0]) ?
		pwdata[7:0] : 8'h00;

	mpsf_w1c_bank #(
		.W(MPSF_FLAG_W),
		.RST_VAL(MPSF_RST_FLAGS)
	) u_flags (
		.clk(clk),
		.rst(rst),
		.set(flag_set),
		.clr(flag_clr),
		.flags(flags)
	);

	// status read view; upper bits reflect live counter state
	always_comb begin
		status_view = 32'h0000_0000;
		status_view[MPSF_DIR_BIT] = count_down;
		status_view[MPSF_CNT_HI:MPSF_CNT_LO] = interval_period_count;
		status_view[MPSF_PRD_BIT:MPSF_OUT_LO] = flags;
	end

	assign irq_en_view = {24'h00_0000, irq_en_q};
	assign src_view = {26'h000_0000, use_trig};

	always_comb begin
		trig_view = 32'h0000_0000;
		if (trig_idx < 3'(MPSF_NCH)) begin
			trig_view[MPSF_TMOD_HI:MPSF_TMOD_LO] = tmode_q[trig_idx];
		end
	end

	assign rd_mux = sel_status ? status_view :
		sel_irq_en ? irq_en_view :
		sel_trig ? trig_view :
		sel_src ? src_view : 32'h0000_0000;

	// read data held from capture through the end of the transfer
	assign rdata_d = (capture && !pwrite) ? rd_mux : rdata_q;

	// enable register write; read-only status bits ignore writes
	always_comb begin
		logic [31:0] merged;
		merged = strb_merge(irq_en_view, pwdata, pstrb);
		irq_en_d = irq_en_q;
		if (wr_fire && sel_irq_en) begin
			irq_en_d = merged[7:0];
		end
	end

	// trigger mode fields, one register per channel
	always_comb begin
		logic [31:0] merged;
		merged = strb_merge(trig_view, pwdata, pstrb);
		for (int i = 0; i < MPSF_NCH; i++) begin
			tmode_d[i] = tmode_q[i];
		end
		if (wr_fire && sel_trig && trig_idx < 3'(MPSF_NCH)) begin
			tmode_d[trig_idx] =
				mpsf_tmode_t'(merged[MPSF_TMOD_HI:MPSF_TMOD_LO]);
		end
	end

	// shared enable bits gate whichever source each flag follows
	assign irq_d = |(flags & irq_en_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdata_q <= MPSF_RST_RDATA;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_q <= MPSF_RST_IRQ_EN;
			irq_q <= 1'b0;
			trig_out_q <= MPSF_RST_TRIG;
		end else begin
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
			trig_out_q <= trig_fire;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MPSF_NCH; i++) begin
				tmode_q[i] <= MPSF_TM_DISABLED;
			end
		end else begin
			for (int i = 0; i < MPSF_NCH; i++) begin
				tmode_q[i] <= tmode_d[i];
			end
		end
	end

	assign prdata = rdata_q;
	assign adc_trig_out = trig_out_q;
	assign irq = irq_q;
endmodule

// ### mpsf_w1c_bank.sv
// bank of sticky event flags, cleared by writing one
`timescale 1ns/1ns
module mpsf_w1c_bank #(
	parameter int unsigned W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// events and clears
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// flag state
	output logic [W-1:0] flags
);
	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	// elaboration check: an empty bank cannot hold a flag
	if (W < 1) begin : g_w_chk
		$error("mpsf_w1c_bank: width must be at least one");
	end

	// zero written keeps the flag, a new event beats the clear
	assign flags_d = (flags_q & ~clr) | set;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= RST_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule

// ### tb.sv
// testbench: status, flags and interrupt of the status flag block
`timescale 1ns/1ns
module tb;
	import mpsf_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic count_down = 1'b0;
	logic [2:0] ipc = 3'b000;
	logic period_evt = 1'b0;
	logic bottom_evt = 1'b0;
	logic [5:0] duty_match = 6'h00;
	logic [5:0] trig_match = 6'h00;
	logic [5:0] adc_trig_out;
	logic irq;
	logic [31:0] rd;
	logic [5:0] trg;
	logic err;
	int failures = 0;
	int checked = 0;
	always #50 clk = ~clk;
	mpsf_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.count_down(count_down), .interval_period_count(ipc),
		.period_evt(period_evt), .bottom_evt(bottom_evt),
		.duty_match(duty_match), .trig_match(trig_match),
		.adc_trig_out(adc_trig_out), .irq(irq));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, e);
	endtask
	task automatic pulse(input logic p, input logic b, input logic [5:0] d,
		input logic [5:0] t);
		@(posedge clk);
		period_evt <= p;
		bottom_evt <= b;
		duty_match <= d;
		trig_match <= t;
		@(posedge clk);
		{period_evt, bottom_evt, duty_match, trig_match} <= 14'h0000;
		@(negedge clk);
		trg = adc_trig_out;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic t_status();
		rdchk(MPSF_OFF_IRQ_EN, 32'h0000_0000);
		apb(1'b1, MPSF_OFF_STATUS, 32'hffff_ffff);
		count_down <= 1'b1;
		ipc <= 3'b101;
		rdchk(MPSF_OFF_STATUS, 32'h0000_d000);
		count_down <= 1'b0;
		ipc <= 3'b010;
		rdchk(MPSF_OFF_STATUS, 32'h0000_2000);
		ipc <= 3'b000;
	endtask
	task automatic t_prd_bot();
		apb(1'b1, MPSF_OFF_IRQ_EN, 32'h0000_00c0);
		for (int i = 0; i < 2; i++) begin
			pulse(i == 0, i == 1, 6'h00, 6'h00);
			check(irq, 1'b1);
			rdchk(MPSF_OFF_STATUS, 32'h80 >> i);
			apb(1'b1, MPSF_OFF_STATUS, 32'h0000_0000);
			rdchk(MPSF_OFF_STATUS, 32'h80 >> i);
			apb(1'b1, MPSF_OFF_STATUS, 32'h80 >> i);
			rdchk(MPSF_OFF_STATUS, 32'h0000_0000);
		end
		period_evt <= 1'b1;
		apb(1'b1, MPSF_OFF_STATUS, 32'h0000_0080);
		period_evt <= 1'b0;
		rdchk(MPSF_OFF_STATUS, 32'h0000_0080);
		apb(1'b1, MPSF_OFF_IRQ_EN, 32'h0000_0000);
		pulse(1'b0, 1'b1, 6'h00, 6'h00);
		check(irq, 1'b0);
		apb(1'b1, MPSF_OFF_STATUS, 32'h0000_00c0);
	endtask
	task automatic t_source();
		apb(1'b1, MPSF_OFF_IRQ_EN, 32'h0000_003f);
		pulse(1'b0, 1'b0, 6'h3f, 6'h00);
		check(irq, 1'b1);
		apb(1'b0, MPSF_OFF_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_003f);
		apb(1'b1, MPSF_OFF_STATUS, rd);
		for (int m = 1; m < 4; m++) begin
			for (int c = 0; c < 6; c++)
				apb(1'b1, 12'h008 + 12'(4 * c), 32'(m) << 16);
			if (m != 3) begin
				count_down <= (m == 1);
				pulse(1'b0, 1'b0, 6'h00, 6'h3f);
				check(trg, 6'h00);
				rdchk(MPSF_OFF_STATUS, {16'h0000, m == 1, 15'h0000});
			end
			count_down <= (m == 2);
			pulse(1'b0, 1'b0, 6'h3f, 6'h00);
			check(trg, 6'h00);
			rdchk(MPSF_OFF_STATUS, {16'h0000, m == 2, 15'h0000});
			pulse(1'b0, 1'b0, 6'h00, 6'h3f);
			check(trg, 6'h3f);
			rdchk(MPSF_OFF_STATUS,
				{16'h0000, m == 2, 9'h000, 6'h3f});
			apb(1'b1, MPSF_OFF_STATUS, 32'h0000_003f);
		end
		apb(1'b1, 12'h008, 32'h0000_0000);
		rdchk(MPSF_OFF_SRC_VIEW, 32'h0000_003e);
		pulse(1'b0, 1'b0, 6'h3f, 6'h00);
		rdchk(MPSF_OFF_STATUS, 32'h0000_0001);
	endtask
	task automatic t_refuse();
		apb(1'b0, 12'h024, 32'h0000_0000);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b1, 12'h006, 32'h0000_0000);
		check(err, 1'b1);
		rdchk(MPSF_OFF_IRQ_EN, 32'h0000_003f);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_status();
		t_prd_bot();
		t_source();
		t_refuse();
		complete_run();
	end
	initial begin
		#(400000);
		failures++;
		complete_run();
	end
endmodule
